// [common/rtwo_pkg.sv]
// Purpose: constants, types and register map of the reload timer block
// Assumes: 32-bit AXI4-Lite, register byte address is four times the index
// Notes: prescaler and timer are both 8 bits wide
//
// Behaviour
// - count source is clock, clock/2, clock/8 or companion timer underflow.
// - periodic mode decrements, reloads primary on underflow, keeps counting.
// - periodic underflow rate is source over (prescaler+1)(primary+1).
// - start bit 1 starts; start bit 0 or forced stop 1 stops.
// - periodic mode raises the interrupt on every timer underflow.
// - periodic writes: stopped loads both; running follows the write control bit.
// - counters take new values only on source ticks or prescaler underflow.
// - waveform mode toggles output each underflow, alternates primary and secondary.
// - waveform periods are (prescaler+1)(primary+1) and (prescaler+1)(secondary+1).
// - waveform interrupt comes with the output change ending the secondary.
// - waveform running writes reach reload only; apply after primary write.
// - output switch accepted at start or interrupt, shown from next primary.
// - one-shot gives one pulse of (prescaler+1)(primary+1) source cycles.
// - one-shot underflow reloads, ends pulse, clears running flag; stop reloads.
// - one-shot pulse starts on trigger only while the start bit is 1.
// - one-shot stops on underflow, one-shot stop, start cleared, forced stop.
// - one-shot interrupt comes with the end of the output pulse.
// - trigger enable bit lets external trigger pin edges start one-shots.
// - one-shot running writes reach reload only, used for the next pulse.
// - forced stop sets reload values to all ones, clears start and flags.
// - two-bit mode field: periodic, waveform, one-shot, wait one-shot.
// - triggers while the one-shot running flag is set are ignored.
// - trigger polarity 0 selects falling edge, 1 selects rising edge.

package rtwo_pkg;

	// ======================================================
	// register indices (byte address is index times four)
	localparam logic [9:0] IDX_COUNT_CTRL = 10'h108;
	localparam logic [9:0] IDX_ONESHOT = 10'h109;
	localparam logic [9:0] IDX_OUTPUT_IO = 10'h10a;
	localparam logic [9:0] IDX_MODE = 10'h10b;
	localparam logic [9:0] IDX_PRESCALER = 10'h10c;
	localparam logic [9:0] IDX_SECONDARY = 10'h10d;
	localparam logic [9:0] IDX_PRIMARY = 10'h10e;

	// ======================================================
	// field positions
	localparam int BIT_START = 0;
	localparam int BIT_STATUS = 1;
	localparam int BIT_FSTOP = 2;
	localparam int BIT_OS_START = 0;
	localparam int BIT_OS_STOP = 1;
	localparam int BIT_OS_RUN = 2;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_WRITE_CONTROL_BIT = 3;
	localparam int BIT_CKS_LO = 4;
	localparam int BIT_CUTOFF = 7;

	// ======================================================
	// reset values and clock/8 divider last count
	localparam logic [7:0] RST_COUNT = 8'hff;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [2:0] DIV8_LAST = 3'h7;

	// ======================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ======================================================
	// types
	typedef enum logic [1:0] {
		MODE_PERIODIC = 2'b00,
		MODE_WAVEFORM = 2'b01,
		MODE_ONESHOT = 2'b10,
		MODE_WAIT_ONESHOT = 2'b11
	} rtwo_mode_e;

	typedef enum logic [1:0] {
		SRC_DIV1 = 2'b00,
		SRC_DIV8 = 2'b01,
		SRC_COMPANION = 2'b10,
		SRC_DIV2 = 2'b11
	} rtwo_src_e;

	typedef struct packed {
		logic cutoff;
		rtwo_src_e src;
		logic write_control_bit;
		rtwo_mode_e mode;
	} rtwo_mode_s;

	typedef struct packed {
		logic polarity;
		logic trig_en;
		logic out_switch;
		logic out_level;
	} rtwo_io_s;

endpackage

// [hdl/rtwo_timer.sv]
// Purpose: 8-bit prescaler plus 8-bit reload timer with three modes
// Assumes: synchronous inputs, AXI4-Lite register access, single clock
// Notes: wait one-shot mode runs like the plain one-shot mode
`timescale 1ns/10ps
`default_nettype none

module rtwo_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic companion_underflow,
	input wire logic external_trigger_pin,
	input wire logic port_latch,
	output logic pulse_output_pin,
	output logic timer_irq
);

	// ======================================================
	// state
	rtwo_pkg::rtwo_mode_s mode_reg;
	rtwo_pkg::rtwo_io_s output_io_control_reg;
	logic count_start_bit;
	logic oneshot_running_flag;
	logic [7:0] prescaler_reg;
	logic [7:0] primary_reg;
	logic [7:0] secondary_reg;
	logic [7:0] sec_active_reg;
	logic [7:0] pre_cnt_reg;
	logic [7:0] tim_cnt_reg;
	logic pre_pend_reg;
	logic tim_pend_reg;
	logic phase_reg;
	logic out_switch_act_reg;
	logic counting_d_reg;
	logic trig_prev_reg;
	logic [2:0] div_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic [9:0] aw_idx_reg;
	logic [7:0] w_data_reg;
	logic w_lane_reg;

	// ======================================================
	// bus write decode
	logic wr_go;
	logic wr_ctrl, wr_os, wr_io, wr_mode, wr_pre, wr_sec, wr_pri;
	logic wr_map;
	logic fstop, start_clr, os_stop, os_trig, ext_edge;
	logic counting, tick, pre_zero, tim_uf, os_mode, wave_mode;
	logic start_rise;
	logic irq_next, out_next;
	logic [7:0] sec_next;

	assign wr_go = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	assign wr_ctrl = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_COUNT_CTRL;
	assign wr_os = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_ONESHOT;
	assign wr_io = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_OUTPUT_IO;
	assign wr_mode = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_MODE;
	assign wr_pre = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_PRESCALER;
	assign wr_sec = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_SECONDARY;
	assign wr_pri = wr_go & w_lane_reg & aw_idx_reg == rtwo_pkg::IDX_PRIMARY;
	assign wr_map = aw_idx_reg >= rtwo_pkg::IDX_COUNT_CTRL &&
		aw_idx_reg <= rtwo_pkg::IDX_PRIMARY;

	// ======================================================
	// control events
	assign fstop = wr_ctrl & w_data_reg[rtwo_pkg::BIT_FSTOP];
	assign start_clr = wr_ctrl & ~w_data_reg[rtwo_pkg::BIT_START];
	assign os_mode = mode_reg.mode[1];
	assign wave_mode = mode_reg.mode == rtwo_pkg::MODE_WAVEFORM;
	// counting runs on the start bit, or on an accepted trigger
	assign counting = os_mode ? oneshot_running_flag : count_start_bit;
	assign start_rise = counting & ~counting_d_reg;

	// trigger pin edge, polarity chosen by software
	assign ext_edge = output_io_control_reg.polarity ?
		(external_trigger_pin & ~trig_prev_reg) :
		(~external_trigger_pin & trig_prev_reg);
	assign os_trig = os_mode & count_start_bit & ~oneshot_running_flag &
		((wr_os & w_data_reg[rtwo_pkg::BIT_OS_START]) |
		(output_io_control_reg.trig_en & ext_edge));

	// ======================================================
	// count source selection
	always_comb begin
		unique case (mode_reg.src)
			rtwo_pkg::SRC_DIV1: tick = 1'b1;
			rtwo_pkg::SRC_DIV2: tick = div_reg[0];
			rtwo_pkg::SRC_DIV8: tick = div_reg == rtwo_pkg::DIV8_LAST;
			rtwo_pkg::SRC_COMPANION: tick = companion_underflow;
		endcase
		// cutting the source or stopping freezes both counters
		tick = tick & ~mode_reg.cutoff & counting & ~start_rise;
	end

	assign pre_zero = tick & ~pre_pend_reg & pre_cnt_reg == 8'h00;
	assign tim_uf = pre_zero & ~tim_pend_reg & tim_cnt_reg == 8'h00;

	// one-shot ends on underflow or any stop request
	assign os_stop = os_mode & (fstop | start_clr |
		(wr_os & w_data_reg[rtwo_pkg::BIT_OS_STOP]) | tim_uf);

	// ======================================================
	// free-running divider for clock/2 and clock/8
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 3'h0;
		end else if (ce) begin
			div_reg <= div_reg + 3'h1;
		end
	end

	// ======================================================
	// control register, start bit and mode settings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_start_bit <= 1'b0;
			mode_reg <= rtwo_pkg::rtwo_mode_s'(rtwo_pkg::RST_CTRL);
			output_io_control_reg <= rtwo_pkg::rtwo_io_s'(4'h0);
		end else if (ce) begin
			if (fstop) begin
				count_start_bit <= 1'b0;
			end else if (wr_ctrl) begin
				count_start_bit <= w_data_reg[rtwo_pkg::BIT_START];
			end
			if (wr_mode) begin
				mode_reg.cutoff <= w_data_reg[rtwo_pkg::BIT_CUTOFF];
				mode_reg.src <= rtwo_pkg::rtwo_src_e'(
					w_data_reg[rtwo_pkg::BIT_CKS_LO +: 2]);
				mode_reg.write_control_bit <= w_data_reg[rtwo_pkg::BIT_WRITE_CONTROL_BIT];
				mode_reg.mode <= rtwo_pkg::rtwo_mode_e'(
					w_data_reg[rtwo_pkg::BIT_MODE_LO +: 2]);
			end
			if (wr_io) begin
				output_io_control_reg <= rtwo_pkg::rtwo_io_s'(w_data_reg[3:0]);
			end
		end
	end

	// ======================================================
	// one-shot running flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oneshot_running_flag <= 1'b0;
			trig_prev_reg <= 1'b0;
			counting_d_reg <= 1'b0;
		end else if (ce) begin
			trig_prev_reg <= external_trigger_pin;
			counting_d_reg <= counting & ~fstop;
			if (fstop || !os_mode) begin
				oneshot_running_flag <= 1'b0;
			end else if (os_stop) begin
				oneshot_running_flag <= 1'b0;
			end else if (os_trig) begin
				oneshot_running_flag <= 1'b1;
			end
		end
	end

	// ======================================================
	// reload registers; secondary shadow applies after a primary write
	always_comb begin
		sec_next = sec_active_reg;
		if (wr_pri && wave_mode) begin
			sec_next = secondary_reg;
		end else if (wr_sec && !counting) begin
			sec_next = w_data_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescaler_reg <= rtwo_pkg::RST_COUNT;
			primary_reg <= rtwo_pkg::RST_COUNT;
			secondary_reg <= rtwo_pkg::RST_COUNT;
			sec_active_reg <= rtwo_pkg::RST_COUNT;
		end else if (ce) begin
			if (fstop) begin
				prescaler_reg <= rtwo_pkg::RST_COUNT;
				primary_reg <= rtwo_pkg::RST_COUNT;
				secondary_reg <= rtwo_pkg::RST_COUNT;
				sec_active_reg <= rtwo_pkg::RST_COUNT;
			end else begin
				if (wr_pre) prescaler_reg <= w_data_reg;
				if (wr_pri) primary_reg <= w_data_reg;
				if (wr_sec) secondary_reg <= w_data_reg;
				sec_active_reg <= sec_next;
			end
		end
	end

	// ======================================================
	// deferred counter loads for running periodic writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_pend_reg <= 1'b0;
			tim_pend_reg <= 1'b0;
		end else if (ce) begin
			if (fstop || !counting) begin
				pre_pend_reg <= 1'b0;
				tim_pend_reg <= 1'b0;
			end else begin
				// a pending prescaler load is taken on the source tick, a timer load on prescaler underflow, never at once
				if (wr_pre && !mode_reg.write_control_bit && !os_mode && !wave_mode) begin
					pre_pend_reg <= 1'b1;
				end else if (tick) begin
					pre_pend_reg <= 1'b0;
				end
				if (wr_pri && !mode_reg.write_control_bit && !os_mode && !wave_mode) begin
					tim_pend_reg <= 1'b1;
				end else if (tick && !pre_pend_reg && pre_cnt_reg == 8'h00) begin
					tim_pend_reg <= 1'b0;
				end
			end
		end
	end

	// ======================================================
	// prescaler and timer counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt_reg <= rtwo_pkg::RST_COUNT;
			tim_cnt_reg <= rtwo_pkg::RST_COUNT;
		end else if (ce) begin
			if (fstop) begin
				pre_cnt_reg <= rtwo_pkg::RST_COUNT;
				tim_cnt_reg <= rtwo_pkg::RST_COUNT;
			end else if (os_stop && oneshot_running_flag) begin
				// reload before halting so the next pulse starts clean
				pre_cnt_reg <= prescaler_reg;
				tim_cnt_reg <= primary_reg;
			end else if (start_rise && wave_mode) begin
				pre_cnt_reg <= prescaler_reg;
				tim_cnt_reg <= primary_reg;
			end else if (!counting) begin
				if (wr_pre) pre_cnt_reg <= w_data_reg;
				if (wr_pri) tim_cnt_reg <= w_data_reg;
				if (wr_sec && wave_mode) tim_cnt_reg <= primary_reg;
			end else if (tick) begin
				if (pre_pend_reg || pre_cnt_reg == 8'h00) begin
					pre_cnt_reg <= prescaler_reg;
				end else begin
					pre_cnt_reg <= pre_cnt_reg - 8'h01;
				end
				if (pre_zero) begin
					if (tim_pend_reg) begin
						tim_cnt_reg <= primary_reg;
					end else if (tim_cnt_reg != 8'h00) begin
						tim_cnt_reg <= tim_cnt_reg - 8'h01;
					end else if (wave_mode && !phase_reg) begin
						tim_cnt_reg <= sec_active_reg;
					end else begin
						tim_cnt_reg <= primary_reg;
					end
				end
			end
		end
	end

	// ======================================================
	// waveform phase and output switch acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 1'b0;
			out_switch_act_reg <= 1'b0;
		end else if (ce) begin
			if (!counting || fstop) begin
				phase_reg <= 1'b0;
			end else if (tim_uf && wave_mode) begin
				phase_reg <= ~phase_reg;
			end
			// taking it only at a period boundary avoids a runt pulse
			if (start_rise || (tim_uf && wave_mode && phase_reg)) begin
				out_switch_act_reg <= output_io_control_reg.out_switch;
			end
		end
	end

	// ======================================================
	// interrupt pulse and output pin
	always_comb begin
		irq_next = 1'b0;
		out_next = port_latch;
		unique case (mode_reg.mode)
			rtwo_pkg::MODE_PERIODIC: begin
				irq_next = tim_uf;
			end
			rtwo_pkg::MODE_WAVEFORM: begin
				irq_next = tim_uf & phase_reg;
				if (!out_switch_act_reg) begin
					if (!counting || fstop) begin
						out_next = output_io_control_reg.out_level;
					end else begin
						// level flips on the same edge as the interrupt
						out_next = output_io_control_reg.out_level ^
							~(phase_reg ^ tim_uf);
					end
				end
			end
			rtwo_pkg::MODE_ONESHOT, rtwo_pkg::MODE_WAIT_ONESHOT: begin
				irq_next = tim_uf;
				out_next = output_io_control_reg.out_level ^
					(oneshot_running_flag & ~os_stop);
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_irq <= 1'b0;
			pulse_output_pin <= 1'b0;
		end else if (ce) begin
			timer_irq <= irq_next;
			pulse_output_pin <= out_next;
		end else begin
			timer_irq <= 1'b0;
		end
	end

	// ======================================================
	// AXI4-Lite write channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_idx_reg <= 10'h000;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rtwo_pkg::RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_idx_reg <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? rtwo_pkg::RESP_OKAY :
					rtwo_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				// free both channels only once the answer is taken
				s_axi_bvalid <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
		end
	end

	// ======================================================
	// read data: counters read back, secondary is write-only
	logic [7:0] rd_byte;
	logic rd_map;
	logic [9:0] rd_idx;

	assign rd_idx = s_axi_araddr[11:2];

	always_comb begin
		rd_byte = 8'h00;
		rd_map = 1'b1;
		case (rd_idx)
			rtwo_pkg::IDX_COUNT_CTRL: begin
				rd_byte[rtwo_pkg::BIT_START] = count_start_bit;
				rd_byte[rtwo_pkg::BIT_STATUS] = counting;
			end
			rtwo_pkg::IDX_ONESHOT:
				rd_byte[rtwo_pkg::BIT_OS_RUN] = oneshot_running_flag;
			rtwo_pkg::IDX_OUTPUT_IO: rd_byte[3:0] = output_io_control_reg;
			rtwo_pkg::IDX_MODE: begin
				rd_byte[rtwo_pkg::BIT_CUTOFF] = mode_reg.cutoff;
				rd_byte[rtwo_pkg::BIT_CKS_LO +: 2] = mode_reg.src;
				rd_byte[rtwo_pkg::BIT_WRITE_CONTROL_BIT] = mode_reg.write_control_bit;
				rd_byte[rtwo_pkg::BIT_MODE_LO +: 2] = mode_reg.mode;
			end
			rtwo_pkg::IDX_PRESCALER: rd_byte = pre_cnt_reg;
			rtwo_pkg::IDX_SECONDARY: rd_byte = 8'h00;
			rtwo_pkg::IDX_PRIMARY: rd_byte = tim_cnt_reg;
			default: rd_map = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= rtwo_pkg::RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_map ? rtwo_pkg::RESP_OKAY :
					rtwo_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // rtwo_timer

`default_nettype wire

// [bench/rtwo_far_model.sv]
// Purpose: far side of the timer pins: trigger source and companion timer
// Assumes: requests arrive as one-cycle strobes just after a clock edge
// Notes: trigger idles at the inverse of the level its active edge reaches
`timescale 1ns/10ps
`default_nettype none
module rtwo_far_model #(
	parameter int COMP_DIV = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fire,
	input wire logic polarity,
	output logic trig_pin,
	output logic comp_uf
);
	logic [1:0] act_cnt;
	logic [7:0] div_cnt;
	// ==========
	// trigger pin, short so a second request makes a fresh edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_cnt <= 2'h0;
		end else if (fire) begin
			act_cnt <= 2'h2;
		end else if (act_cnt != 2'h0) begin
			act_cnt <= act_cnt - 2'h1;
		end
	end
	assign trig_pin = polarity ~^ (act_cnt != 2'h0);
	// ==========
	// companion underflow strobe, free running
	always_ff @(posedge aclk) begin
		if (!aresetn || div_cnt == 8'(COMP_DIV - 1)) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	assign comp_uf = aresetn && (div_cnt == 8'(COMP_DIV - 1));
endmodule // rtwo_far_model
`default_nettype wire

// [bench/rtwo_sva.sv]
// Purpose: port assertions for the reload timer
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module rtwo_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pulse_output_pin,
	input wire logic timer_irq
);
	// ==========
	// clocking and handshake steps
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// ==========
	// bus answers; a pending request blocks new ones
	a_b_follows: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_aw_refused: assert property (s_wr_taken
		|=> (!s_axi_awready && !s_axi_wready) [*2])
		else $error("second write accepted");
	a_r_follows: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	// ==========
	// interrupt and pin
	a_irq_single: assert property (
		timer_irq |=> !timer_irq) else $error("interrupt wider than one cycle");
	a_irq_gated: assert property (!ce |=> !timer_irq)
		else $error("interrupt while clock enable low");
	a_pin_frozen: assert property (!ce |=> $stable(pulse_output_pin))
		else $error("pin moved while frozen");
endmodule // rtwo_sva
`default_nettype wire

// [bench/test_reload_timer_waveform_oneshot.sv]
// Purpose: self-checking bench for the reload timer
// Assumes: register byte address is four times its index
// Notes: periods and widths drawn from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module test_reload_timer_waveform_oneshot;
	localparam int COMP_DIV = 3;
	localparam int LIMIT = 4000;
	localparam logic [9:0] A_CTRL = rtwo_pkg::IDX_COUNT_CTRL,
		A_OSH = rtwo_pkg::IDX_ONESHOT, A_IO = rtwo_pkg::IDX_OUTPUT_IO,
		A_MODE = rtwo_pkg::IDX_MODE, A_PRE = rtwo_pkg::IDX_PRESCALER,
		A_SEC = rtwo_pkg::IDX_SECONDARY, A_PRI = rtwo_pkg::IDX_PRIMARY;
	localparam logic [9:0] RIDX [8] = '{A_CTRL, A_OSH, A_IO, A_MODE, A_PRE,
		A_SEC, A_PRI, 10'h107};
	localparam logic [7:0] RVAL [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'hff, 8'h00, 8'hff, 8'h00};
	logic aclk, aresetn, ce, port_latch, fire, polarity;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, companion_underflow;
	logic external_trigger_pin, pulse_output_pin, timer_irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rdv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0] pre, pri, sec;
	int n_errors, tests_run, gap, hi, lo;
	wire logic [31:0] pin_w = {31'h0, pulse_output_pin};
	// ==========
	// clock and instances
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	rtwo_timer u_dut (.*);
	rtwo_far_model #(.COMP_DIV(COMP_DIV)) u_far (.aclk(aclk),
		.aresetn(aresetn), .fire(fire), .polarity(polarity),
		.trig_pin(external_trigger_pin), .comp_uf(companion_underflow));
	// ==========
	// helpers: random draw, expected length, compare, verdict
	function automatic logic [7:0] rnd(input int m);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return 8'(seed % m);
	endfunction
	function automatic int ticks(input logic [1:0] s, input int n, input int m);
		int d;
		d = (s == rtwo_pkg::SRC_DIV8) ? 8 : (s == rtwo_pkg::SRC_DIV2) ? 2 : 1;
		if (s == rtwo_pkg::SRC_COMPANION) d = COMP_DIV;
		return d * (n + 1) * (m + 1);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic hang(input string nm);
		n_errors++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		summarize();
	endtask
	// ==========
	// bus master; ready for the answer from the start
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k == 50) hang("write");
	endtask
	task automatic rd(input logic [9:0] idx);
		int k;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k == 50) hang("read");
	endtask
	// ==========
	// pin and interrupt timing, all sampled at rising edges
	task automatic wait_pin(input logic lvl);
		int k;
		for (k = 0; k < LIMIT; k++) begin
			@(posedge aclk);
			if (pulse_output_pin === lvl) break;
		end
		if (k == LIMIT) hang("pin level");
	endtask
	task automatic hold(input logic lvl, output int c);
		c = 1;
		while (c < LIMIT) begin
			@(posedge aclk);
			if (pulse_output_pin !== lvl) break;
			c++;
		end
	endtask
	task automatic irq_gap();
		int k;
		for (k = 0; k < LIMIT; k++) begin
			@(posedge aclk);
			if (timer_irq === 1'b1) break;
		end
		if (k == LIMIT) hang("interrupt");
		gap = 0;
		do begin
			@(posedge aclk);
			gap++;
		end while (timer_irq !== 1'b1 && gap < LIMIT);
	endtask
	task automatic fire_once();
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
	endtask
	// ==========
	// main sequence
	initial begin
		{aresetn, port_latch, fire, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		ce = 1'b1;
		polarity = 1'b1;
		seed = 32'he84f;
		n_errors = 0;
		tests_run = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(RIDX[i]);
			chk("reset value", {24'h000000, RVAL[i]}, rdv);
			chk("read resp", (i == 7) ? 2'h2 : 2'h0, {30'h0, rsp});
		end
		wr(10'h107, 8'h5a);
		chk("unmapped write", {30'h0, rtwo_pkg::RESP_SLVERR}, {30'h0, rsp});
		// periodic mode, every count source
		for (int s = 0; s < 4; s++) begin
			pre = rnd(4) + 8'h01;
			pri = rnd(8);
			wr(A_PRE, pre);
			wr(A_PRI, pri);
			wr(A_MODE, {2'b00, 2'(s), 4'h0});
			wr(A_CTRL, 8'h01);
			irq_gap();
			chk("periodic gap", ticks(2'(s), pre, pri), gap);
			wr(A_CTRL, 8'h00);
			rd(A_CTRL);
			chk("status after stop", 32'h0, rdv);
		end
		// reload-only rewrite, freeze, port use
		wr(A_PRE, 8'h00);
		wr(A_PRI, 8'h05);
		wr(A_MODE, 8'h08);
		wr(A_CTRL, 8'h01);
		irq_gap();
		chk("gap before rewrite", 32'd6, gap);
		wr(A_PRI, 8'h02);
		irq_gap();
		chk("gap after rewrite", 32'd3, gap);
		ce <= 1'b0;
		repeat (10) @(posedge aclk);
		ce <= 1'b1;
		port_latch <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("port latch on pin", 32'h1, pin_w);
		port_latch <= 1'b0;
		wr(A_CTRL, 8'h04);
		rd(A_PRI);
		chk("forced stop primary", 32'hff, rdv);
		rd(A_CTRL);
		chk("forced stop flags", 32'h0, rdv);
		// waveform: secondary, then primary
		pre = rnd(2);
		pri = rnd(8) + 8'h01;
		sec = rnd(8) + 8'h01;
		wr(A_PRE, pre);
		wr(A_SEC, sec);
		wr(A_PRI, pri);
		wr(A_MODE, 8'h09);
		wr(A_CTRL, 8'h01);
		wait_pin(1'b1);
		hold(1'b1, hi);
		hold(1'b0, lo);
		chk("irq at secondary end", 32'h1, {31'h0, timer_irq});
		hold(1'b1, hi);
		chk("secondary width", ticks(2'b00, pre, sec), lo);
		chk("primary width", ticks(2'b00, pre, pri), hi);
		wr(A_CTRL, 8'h00);
		wr(A_IO, 8'h02);
		repeat (3) @(posedge aclk);
		chk("stopped level", 32'h0, pin_w);
		wr(A_CTRL, 8'h01);
		irq_gap();
		chk("switched to latch", 32'h0, pin_w);
		wr(A_CTRL, 8'h04);
		// pin-triggered one-shot, both edges, retrigger
		pri = rnd(8) + 8'h06;
		wr(A_PRE, 8'h03);
		wr(A_PRI, pri);
		wr(A_MODE, 8'h0a);
		for (int p = 0; p < 2; p++) begin
			polarity <= p[0];
			wr(A_IO, {4'h0, p[0], 3'b100});
			wr(A_CTRL, 8'h01);
			fire_once();
			wait_pin(1'b1);
			fork
				hold(1'b1, hi);
				begin
					repeat (2) @(posedge aclk);
					fire_once();
				end
			join
			chk("one-shot width", ticks(2'b00, 3, pri), hi);
			chk("irq at pulse end", 32'h1, {31'h0, timer_irq});
			rd(A_OSH);
			chk("running flag", 32'h0, rdv);
			wr(A_CTRL, 8'h00);
		end
		// soft trigger; ignored when disabled or stopped
		wr(A_IO, 8'h00);
		wr(A_OSH, 8'h01);
		wr(A_CTRL, 8'h01);
		fire_once();
		repeat (20) @(posedge aclk);
		chk("no pulse", 32'h0, pin_w);
		wr(A_OSH, 8'h01);
		wait_pin(1'b1);
		hold(1'b1, hi);
		chk("soft trigger width", ticks(2'b00, 3, pri), hi);
		wr(A_OSH, 8'h01);
		wait_pin(1'b1);
		wr(A_OSH, 8'h02);
		repeat (2) @(posedge aclk);
		chk("pin after one-shot stop", 32'h0, pin_w);
		rd(A_OSH);
		chk("flag after one-shot stop", 32'h0, rdv);
		summarize();
	end
endmodule // test_reload_timer_waveform_oneshot
bind rtwo_timer rtwo_sva u_sva (.*);
`default_nettype wire
